// file: hw/bct_defines.svh
// offsets, field positions, reset values and timing figures of the bonding change handler
`ifndef BCT_DEFINES_SVH
`define BCT_DEFINES_SVH

// ----------------------------------------------------------------
// clock and time figures
// ----------------------------------------------------------------
`define BCT_CLK_MHZ        25
`define BCT_REASM_TIME_US  1000
`define BCT_ACK_TIME_US    1000
`define BCT_RSP_RETRIES    4'h3
`define BCT_REQ_RETRIES    4'h3

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BCT_OFF_CTRL       12'h000
`define BCT_OFF_STATUS     12'h004
`define BCT_OFF_ERRCNT     12'h008
`define BCT_OFF_REASM_LIM  12'h00C
`define BCT_OFF_ACK_LIM    12'h010

// ----------------------------------------------------------------
// register fields and reset values
// ----------------------------------------------------------------
`define BCT_CTRL_EN        0
`define BCT_CTRL_RETRY_LO  8
`define BCT_CTRL_RETRY_HI  11
`define BCT_CTRL_RST       32'h0000_0301

// ----------------------------------------------------------------
// upstream channel action codes
// ----------------------------------------------------------------
`define BCT_US_ACT_ADD     3'h1
`define BCT_US_ACT_REPLACE 3'h4

// ----------------------------------------------------------------
// request attribute flag positions
// ----------------------------------------------------------------
`define BCT_FLAG_W         20
`define BCT_F_FMT_BAD      0
`define BCT_F_RCC_PRIM     1
`define BCT_F_INIT_TECH    2
`define BCT_F_RCS_CHANGE   3
`define BCT_F_SIMPLIFIED   4
`define BCT_F_PRIM_ONE     5
`define BCT_F_PRIM_ASSIGN  6
`define BCT_F_OFDM_DS      7
`define BCT_F_DS_PROFILE   8
`define BCT_F_HAS_UCD      9
`define BCT_F_US_OFDMA     10
`define BCT_F_DATA_IUC     11
`define BCT_F_LIGHT_SLEEP  12
`define BCT_F_TUNE_BAD     13
`define BCT_F_PHY_BAD      14
`define BCT_F_RESEQ_MIS    15
`define BCT_F_SIDCL_MIS    16
`define BCT_F_MAC_UNKNOWN  17
`define BCT_F_RCC_SAME     18
`define BCT_F_ADDS_EXIST   19

// ----------------------------------------------------------------
// resource counts
// ----------------------------------------------------------------
`define BCT_NUM_RES        6
`define BCT_RES_W          8

`endif

// file: hw/bct_pkg.sv
// types shared by the bonding change handler
package bct_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REASM,
    ST_ACQ,
    ST_ACK
  } bct_state_e;

  typedef enum logic [2:0] {
    CODE_OK,
    CODE_INVALID,
    CODE_INCAPABLE,
    CODE_INCONSISTENT,
    CODE_INCOMPLETE,
    CODE_ALREADY_THERE,
    CODE_PARTIAL
  } bct_code_e;

endpackage

// file: hw/bct_handler.sv
// modem-side bonding change transaction handler with apb registers
//
// Contract
// - start reassembly timer on first request fragment; covers all remaining fragments
// - on reassembly expiry send response with request-incomplete code, back to idle
// - reject invalid requests, bad format, and those inconsistent with capability
// - invalid if config touches primary downstream without initialization technique
// - invalid if full receive set change lacks exactly one primary channel
// - invalid if simplified receive set change omits primary channel assignment
// - invalid if simplified change with OFDM downstream omits profile assignment
// - invalid while headend flow add, change or channel change is in progress
// - invalid if upstream action add or replace lacks channel descriptor
// - invalid if add or replace of OFDMA upstream lacks data usage code
// - invalid if light-sleep encodings arrive while energy management active
// - incapable if any resource need exceeds modem capability, tuning or phy
// - inconsistent if channel sets disagree with resequencing list or cluster map
// - inconsistent if client MAC address missing from forwarding table
// - valid request with unacquired channels answers partial service per direction
// - on collision bonding change wins; modem executes it, abandoning own flow
// - resend response on ack timeout up to retry limit, then log error
// - redundant if same receive config, existing identifier or channel added
// - redundant request not executed; answer already-present code
`include "bct_defines.svh"

module bct_handler
  import bct_pkg::*;
#(
  parameter logic [31:0] REASM_CYC = 32'(`BCT_REASM_TIME_US * `BCT_CLK_MHZ),
  parameter logic [31:0] ACK_CYC   = 32'(`BCT_ACK_TIME_US * `BCT_CLK_MHZ),
  parameter logic [`BCT_NUM_RES*`BCT_RES_W-1:0] RES_CAP = {`BCT_NUM_RES{8'h08}}
) (
  // clock and reset
  input  wire logic                                 mclk,
  input  wire logic                                 reset,
  // apb slave
  input  wire logic [11:0]                          paddr,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // request fragments from the message parser
  input  wire logic                                 frag_valid,
  input  wire logic                                 frag_first,
  input  wire logic                                 frag_last,
  input  wire logic                                 frag_err,
  input  wire logic [`BCT_FLAG_W-1:0]               req_flags,
  input  wire logic [2:0]                           req_us_action,
  input  wire logic [`BCT_NUM_RES*`BCT_RES_W-1:0]   req_need,
  // modem state
  input  wire logic                                 headend_txn_busy,
  input  wire logic                                 own_flow_pending,
  input  wire logic                                 energy_mode_active,
  // channel acquisition
  input  wire logic                                 acq_done,
  input  wire logic                                 acq_ds_fail,
  input  wire logic                                 acq_us_fail,
  // acknowledgement
  input  wire logic                                 ack_rx,
  // response and status
  output logic                                      rsp_valid,
  output bct_code_e                                 rsp_code,
  output logic                                      exec_start,
  output logic                                      flow_yield,
  output logic                                      partial_ds,
  output logic                                      partial_us,
  output logic                                      err_log,
  output logic                                      busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bct_state_e  state_ff;
  logic [31:0] cnt_ff;
  logic        bad_ff;
  logic [3:0]  retry_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] reasm_lim_ff;
  logic [31:0] ack_lim_ff;
  logic [15:0] errcnt_ff;
  logic        rsp_valid_ff;
  bct_code_e   rsp_code_ff;
  logic        exec_ff;
  logic        yield_ff;
  logic        pds_ff;
  logic        pus_ff;
  logic        err_ff;
  logic        busy_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;

  logic        enable;
  logic [3:0]  retry_lim;
  logic        tmo;
  logic        decide;
  logic        inv;
  logic        incap;
  logic        incons;
  logic        redund;
  logic        us_addrep;
  logic [`BCT_NUM_RES-1:0] over;
  bct_code_e   nxt_code;

  assign enable    = ctrl_ff[`BCT_CTRL_EN];
  assign retry_lim = ctrl_ff[`BCT_CTRL_RETRY_HI:`BCT_CTRL_RETRY_LO];

  // ----------------------------------------------------------------
  // request classification
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `BCT_NUM_RES; gi++) begin : g_res
      assign over[gi] = req_need[gi*`BCT_RES_W +: `BCT_RES_W] >
                        RES_CAP[gi*`BCT_RES_W +: `BCT_RES_W];
    end
  endgenerate

  // a request is judged once its last fragment lands with every fragment clean
  assign decide = frag_valid && frag_last && !frag_err &&
                  ((state_ff == ST_IDLE && frag_first && enable) ||
                   (state_ff == ST_REASM && !bad_ff));

  assign us_addrep = (req_us_action == `BCT_US_ACT_ADD) ||
                     (req_us_action == `BCT_US_ACT_REPLACE);

  always_comb begin
    inv = 1'b0;
    inv = inv | req_flags[`BCT_F_FMT_BAD];
    inv = inv | (req_flags[`BCT_F_RCC_PRIM] & ~req_flags[`BCT_F_INIT_TECH]);
    inv = inv | (req_flags[`BCT_F_RCS_CHANGE] & ~req_flags[`BCT_F_SIMPLIFIED] &
                 ~req_flags[`BCT_F_PRIM_ONE]);
    inv = inv | (req_flags[`BCT_F_RCS_CHANGE] & req_flags[`BCT_F_SIMPLIFIED] &
                 ~req_flags[`BCT_F_PRIM_ASSIGN]);
    inv = inv | (req_flags[`BCT_F_RCS_CHANGE] & req_flags[`BCT_F_SIMPLIFIED] &
                 req_flags[`BCT_F_OFDM_DS] & ~req_flags[`BCT_F_DS_PROFILE]);
    inv = inv | headend_txn_busy;
    inv = inv | (us_addrep & ~req_flags[`BCT_F_HAS_UCD]);
    inv = inv | (us_addrep & req_flags[`BCT_F_US_OFDMA] & ~req_flags[`BCT_F_DATA_IUC]);
    inv = inv | (req_flags[`BCT_F_LIGHT_SLEEP] & energy_mode_active);
  end

  assign incap  = (|over) | req_flags[`BCT_F_TUNE_BAD] | req_flags[`BCT_F_PHY_BAD];
  assign incons = req_flags[`BCT_F_RESEQ_MIS] | req_flags[`BCT_F_SIDCL_MIS] |
                  req_flags[`BCT_F_MAC_UNKNOWN];
  assign redund = req_flags[`BCT_F_RCC_SAME] | req_flags[`BCT_F_ADDS_EXIST];

  // invalid outranks incapable, which outranks redundant
  always_comb begin
    nxt_code = CODE_OK;
    if (inv) begin
      nxt_code = CODE_INVALID;
    end else if (incap) begin
      nxt_code = CODE_INCAPABLE;
    end else if (incons) begin
      nxt_code = CODE_INCONSISTENT;
    end else if (redund) begin
      nxt_code = CODE_ALREADY_THERE;
    end
  end

  // ----------------------------------------------------------------
  // transaction sequencer
  // ----------------------------------------------------------------
  // limits held in registers
  assign tmo = (cnt_ff + 32'h1) >= ((state_ff == ST_REASM) ? reasm_lim_ff : ack_lim_ff);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 32'h0;
      bad_ff       <= 1'b0;
      retry_ff     <= 4'h0;
      rsp_valid_ff <= 1'b0;
      rsp_code_ff  <= CODE_OK;
      exec_ff      <= 1'b0;
      yield_ff     <= 1'b0;
      pds_ff       <= 1'b0;
      pus_ff       <= 1'b0;
      err_ff       <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      exec_ff      <= 1'b0;
      yield_ff     <= 1'b0;
      err_ff       <= 1'b0;
      cnt_ff       <= cnt_ff + 32'h1;
      if (decide) begin
        cnt_ff   <= 32'h0;
        retry_ff <= 4'h0;
        if (nxt_code == CODE_OK) begin
          // bonding change wins over own flow request
          exec_ff  <= 1'b1;
          yield_ff <= own_flow_pending;
          state_ff <= ST_ACQ;
        end else begin
          rsp_valid_ff <= 1'b1;
          rsp_code_ff  <= nxt_code;
          state_ff     <= ST_ACK;
        end
      end else begin
        case (state_ff)
          ST_IDLE: begin
            if (frag_valid && frag_first && enable) begin
              state_ff <= ST_REASM;
              cnt_ff   <= 32'h0;
              bad_ff   <= frag_err;
            end
          end
          ST_REASM: begin
            if (frag_valid && frag_err) begin
              bad_ff <= 1'b1;
            end
            if (tmo) begin
              rsp_valid_ff <= 1'b1;
              rsp_code_ff  <= CODE_INCOMPLETE;
              state_ff     <= ST_IDLE;
            end
          end
          ST_ACQ: begin
            if (acq_done) begin
              pds_ff       <= acq_ds_fail;
              pus_ff       <= acq_us_fail;
              rsp_valid_ff <= 1'b1;
              rsp_code_ff  <= (acq_ds_fail || acq_us_fail) ? CODE_PARTIAL : CODE_OK;
              cnt_ff       <= 32'h0;
              state_ff     <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (ack_rx) begin
              state_ff <= ST_IDLE;
            end else if (tmo) begin
              cnt_ff <= 32'h0;
              if (retry_ff < retry_lim) begin
                retry_ff     <= retry_ff + 4'h1;
                rsp_valid_ff <= 1'b1;
              end else begin
                err_ff   <= 1'b1;
                state_ff <= ST_IDLE;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (state_ff != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_hit;
  logic [31:0] rd_val;

  assign wr_en = psel && penable && pready_ff && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      `BCT_OFF_CTRL:      rd_val = ctrl_ff;
      `BCT_OFF_STATUS:    rd_val = {24'h0, busy_ff, rsp_code_ff, pus_ff, pds_ff, state_ff};
      `BCT_OFF_ERRCNT:    rd_val = {16'h0, errcnt_ff};
      `BCT_OFF_REASM_LIM: rd_val = reasm_lim_ff;
      `BCT_OFF_ACK_LIM:   rd_val = ack_lim_ff;
      default:            rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      // one wait-free access cycle after every setup cycle
      pready_ff  <= psel && !penable;
      prdata_ff  <= (psel && !penable && !pwrite) ? rd_val : 32'h0;
      pslverr_ff <= psel && !penable && !rd_hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff      <= `BCT_CTRL_RST;
      reasm_lim_ff <= REASM_CYC;
      ack_lim_ff   <= ACK_CYC;
    end else if (wr_en) begin
      case (paddr)
        `BCT_OFF_CTRL:      ctrl_ff      <= pwdata & 32'h0000_0F01;
        `BCT_OFF_REASM_LIM: reasm_lim_ff <= pwdata;
        `BCT_OFF_ACK_LIM:   ack_lim_ff   <= pwdata;
        default:            ctrl_ff      <= ctrl_ff;
      endcase
    end
  end

  // a give-up in the same cycle as a clear still counts
  always_ff @(posedge mclk) begin
    if (reset) begin
      errcnt_ff <= 16'h0;
    end else if (wr_en && paddr == `BCT_OFF_ERRCNT) begin
      errcnt_ff <= err_ff ? 16'h1 : 16'h0;
    end else if (err_ff && errcnt_ff != 16'hFFFF) begin
      errcnt_ff <= errcnt_ff + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign rsp_valid  = rsp_valid_ff;
  assign rsp_code   = rsp_code_ff;
  assign exec_start = exec_ff;
  assign flow_yield = yield_ff;
  assign partial_ds = pds_ff;
  assign partial_us = pus_ff;
  assign err_log    = err_ff;
  assign busy       = busy_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  reasm_start_a: assert property (
    state_ff == ST_IDLE && frag_valid && frag_first && !frag_last && enable
    |=> state_ff == ST_REASM && cnt_ff == 32'h0)
    else $error("reassembly timer not started");

  reasm_expiry_a: assert property (
    state_ff == ST_REASM && tmo && !decide
    |=> rsp_valid_ff && rsp_code_ff == CODE_INCOMPLETE && state_ff == ST_IDLE)
    else $error("reassembly expiry not answered");

  invalid_rsp_a: assert property (
    decide && inv |=> rsp_valid_ff && rsp_code_ff == CODE_INVALID && !exec_ff)
    else $error("invalid request not rejected");

  txn_busy_a: assert property (
    decide && headend_txn_busy |=> rsp_code_ff == CODE_INVALID && state_ff == ST_ACK)
    else $error("busy transaction not refused");

  partial_svc_a: assert property (
    state_ff == ST_ACQ && acq_done && !decide && (acq_ds_fail || acq_us_fail)
    |=> rsp_code_ff == CODE_PARTIAL && pds_ff == $past(acq_ds_fail)
        && pus_ff == $past(acq_us_fail))
    else $error("partial service not reported");

  redundant_rsp_a: assert property (
    decide && redund && !inv && !incap && !incons
    |=> rsp_code_ff == CODE_ALREADY_THERE && !exec_ff)
    else $error("redundant request executed");

  collision_win_a: assert property (
    decide && nxt_code == CODE_OK && own_flow_pending
    |=> exec_ff && yield_ff && state_ff == ST_ACQ)
    else $error("bonding change did not win collision");

  ack_retry_a: assert property (
    state_ff == ST_ACK && !ack_rx && !decide && tmo && retry_ff < retry_lim
    |=> rsp_valid_ff && retry_ff == $past(retry_ff) + 4'h1)
    else $error("response not retried");

  ack_giveup_a: assert property (
    state_ff == ST_ACK && !ack_rx && !decide && tmo && retry_ff >= retry_lim
    |=> err_ff && state_ff == ST_IDLE ##1 !err_ff)
    else $error("give-up not logged");

  apb_ready_a: assert property (
    psel && !penable |=> pready_ff)
    else $error("apb access not answered");

endmodule

// file: dv/bct_headend_model.sv
// headend model: issues requests, acknowledges responses, resends after incomplete
`include "bct_defines.svh"
module bct_headend_model
  import bct_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // bench commands
  input  wire logic                   send,
  input  wire logic                   two,
  input  wire logic                   bad,
  input  wire logic                   ack_en,
  input  wire logic [`BCT_FLAG_W-1:0] flags_in,
  input  wire logic [2:0]             act_in,
  input  wire logic [47:0]            need_in,
  // modem side
  input  wire logic                   rsp_valid,
  input  wire bct_code_e              rsp_code,
  output logic                        frag_valid,
  output logic                        frag_first,
  output logic                        frag_last,
  output logic                        frag_err,
  output logic [`BCT_FLAG_W-1:0]      req_flags,
  output logic [2:0]                  req_us_action,
  output logic [47:0]                 req_need,
  output logic                        ack_rx
);
  logic [`BCT_FLAG_W-1:0] flags_ff;
  logic [2:0]             act_ff;
  logic [47:0]            need_ff;
  logic                   second_ff;
  logic [3:0]             n_resend_ff;
  logic                   retry;

  // ------------------------------------------------------------
  // request issue
  // ------------------------------------------------------------
  // resend the same request until the retry limit is used up
  assign retry = rsp_valid & (rsp_code == CODE_INCOMPLETE) & (n_resend_ff < `BCT_REQ_RETRIES);

  // the bench only asks for a request once the modem is idle
  always_ff @(posedge mclk) begin
    frag_valid <= 1'b0;
    frag_err <= 1'b0;
    second_ff <= 1'b0;
    // attribute lines are only meaningful with a fragment; toggle them otherwise
    req_flags <= ~req_flags;
    req_us_action <= ~req_us_action;
    req_need <= ~req_need;
    if (reset) begin
      n_resend_ff <= 4'h0;
      req_flags <= '0;
      req_us_action <= 3'h0;
      req_need <= '0;
    end else if (send | second_ff | retry) begin
      frag_valid <= 1'b1;
      frag_first <= ~second_ff;
      frag_last <= second_ff | retry | ~two;
      frag_err <= send & bad;
      second_ff <= send & two;
      req_flags <= send ? flags_in : flags_ff;
      req_us_action <= send ? act_in : act_ff;
      req_need <= send ? need_in : need_ff;
      if (send) begin
        flags_ff <= flags_in;
        act_ff <= act_in;
        need_ff <= need_in;
      end
      if (retry) begin
        n_resend_ff <= n_resend_ff + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // acknowledgement
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    ack_rx <= ~reset & ack_en & rsp_valid & (rsp_code != CODE_INCOMPLETE);
  end
endmodule

// file: dv/bct_handler_tb.sv
// self-checking bench for the bonding change handler
`include "bct_defines.svh"
module bct_handler_tb
  import bct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] LIM = 32'h0000_0014;
  int                     failures;
  int                     n_checks;
  int                     n_err;
  int                     n_rty;
  logic                   mclk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, r;
  logic                   e, send, two, bad, ack_en, ack_rx, acq_done, acq_ds_fail, acq_us_fail;
  logic                   frag_valid, frag_first, frag_last, frag_err, headend_txn_busy;
  logic                   own_flow_pending, energy_mode_active, rsp_valid, exec_start;
  logic                   flow_yield, partial_ds, partial_us, err_log, busy;
  logic [19:0]            flags_in, req_flags;
  logic [2:0]             act_in, req_us_action;
  logic [47:0]            need_in, req_need;
  bct_code_e              rsp_code;

  bct_handler #(.REASM_CYC(LIM), .ACK_CYC(LIM)) dut (.mclk, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .frag_valid, .frag_first, .frag_last,
    .frag_err, .req_flags, .req_us_action, .req_need, .headend_txn_busy, .own_flow_pending,
    .energy_mode_active, .acq_done, .acq_ds_fail, .acq_us_fail, .ack_rx, .rsp_valid,
    .rsp_code, .exec_start, .flow_yield, .partial_ds, .partial_us, .err_log, .busy);
  bct_headend_model he (.mclk, .reset, .send, .two, .bad, .ack_en, .flags_in, .act_in,
    .need_in, .rsp_valid, .rsp_code, .frag_valid, .frag_first, .frag_last, .frag_err,
    .req_flags, .req_us_action, .req_need, .ack_rx);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic bct_code_e exp_code(input logic [19:0] f, input logic [2:0] a,
                                         input logic [47:0] n, input logic b, input logic m);
    logic ar, cap;
    ar = (a == `BCT_US_ACT_ADD) || (a == `BCT_US_ACT_REPLACE);
    cap = f[13] | f[14];
    for (int k = 0; k < `BCT_NUM_RES; k++) cap |= n[k*8 +: 8] > 8'h08;
    if (f[0] | (f[1] & ~f[2]) | (f[3] & ~f[4] & ~f[5]) | (f[3] & f[4] & ~f[6])
        | (f[3] & f[4] & f[7] & ~f[8]) | b | (ar & ~f[9]) | (ar & f[10] & ~f[11]) | (f[12] & m))
      return CODE_INVALID;
    if (cap) return CODE_INCAPABLE;
    if (f[15] | f[16] | f[17]) return CODE_INCONSISTENT;
    if (f[18] | f[19]) return CODE_ALREADY_THERE;
    return CODE_OK;
  endfunction

  task automatic wait_out(output int c);
    for (c = 1; c < 80; c++) begin
      @(posedge mclk);
      #1;
      if (rsp_valid === 1'b1 || exec_start === 1'b1) break;
    end
  endtask

  task automatic txn(input logic [19:0] f, input logic [2:0] a, input logic [47:0] n,
                     input logic tw, input logic bd);
    int c;
    logic hb, own, em, ds, us;
    bct_code_e x;
    hb = ($urandom % 4) == 0;
    own = 1'($urandom % 2);
    em = 1'($urandom % 2);
    x = exp_code(f, a, n, hb, em);
    @(posedge mclk);
    headend_txn_busy <= hb;
    own_flow_pending <= own;
    energy_mode_active <= em;
    flags_in <= f;
    act_in <= a;
    need_in <= n;
    two <= tw;
    bad <= bd;
    send <= 1'b1;
    @(posedge mclk);
    send <= 1'b0;
    wait_out(c);
    if (bd) begin
      chk(32'(c >= 19 && c <= 23), 1);
      chk(32'(rsp_code), 32'(CODE_INCOMPLETE));
      wait_out(c);
    end
    if (x == CODE_OK) begin
      chk(32'(exec_start), 1);
      chk(32'(flow_yield), 32'(own));
      ds = 1'($urandom % 2);
      us = 1'($urandom % 2);
      @(posedge mclk);
      acq_done <= 1'b1;
      acq_ds_fail <= ds;
      acq_us_fail <= us;
      @(posedge mclk);
      acq_done <= 1'b0;
      acq_ds_fail <= ~ds;
      acq_us_fail <= ~us;
      #1;
      chk(32'(rsp_valid), 1);
      chk(32'(rsp_code), 32'((ds | us) ? CODE_PARTIAL : CODE_OK));
      chk(32'({partial_ds, partial_us}), 32'({ds, us}));
    end else begin
      chk(32'({rsp_valid, exec_start}), 32'h2);
      chk(32'(rsp_code), 32'(x));
    end
    repeat (3) @(posedge mclk);
    #1;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
      n_err += int'(err_log === 1'b1);
      n_rty += int'(rsp_valid === 1'b1);
    end
    chk(32'(busy), 0);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    test_done();
  end

  initial begin
    int p;
    {psel, penable, pwrite, send, two, bad, acq_done, acq_ds_fail, acq_us_fail} = '0;
    {headend_txn_busy, own_flow_pending, energy_mode_active, paddr, pwdata} = '0;
    {flags_in, act_in, need_in} = '0;
    ack_en = 1'b1;
    reset = 1'b1;
    void'($urandom(7847));
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    apb(0, `BCT_OFF_CTRL, 0);
    chk(r, `BCT_CTRL_RST);
    apb(0, `BCT_OFF_REASM_LIM, 0);
    chk(r, LIM);
    apb(0, `BCT_OFF_ACK_LIM, 0);
    chk(r, LIM);
    apb(1, `BCT_OFF_STATUS, 32'hFFFF_FFFF);
    apb(0, `BCT_OFF_STATUS, 0);
    chk(r, 0);
    apb(0, 12'h020, 0);
    chk({r[30:0], e}, 1);
    txn(0, 0, 0, 1, 1);
    for (int b = 0; b < 20; b++) txn(20'h1 << b, 0, 0, 0, 0);
    for (int a = 0; a < 8; a++) txn(20'h0, 3'(a), 0, 0, 0);
    txn(20'h0, 0, {6{8'h08}}, 1, 0);
    txn(20'h0, 0, {8'h09, 40'h0}, 0, 0);
    for (int k = 0; k < 30; k++) begin
      txn(($urandom % 3 == 0) ? 20'h0 : 20'($urandom & $urandom & $urandom),
          3'($urandom), {8'($urandom % 10), 40'h0}, 1'($urandom % 2), 0);
    end
    apb(1, `BCT_OFF_CTRL, 32'h0000_0101);
    ack_en <= 1'b0;
    txn(20'h1, 0, 0, 0, 0);
    apb(0, `BCT_OFF_ERRCNT, 0);
    chk(r, 1);
    chk(32'(n_err), 1);
    chk(32'(n_rty), 1);
    apb(0, `BCT_OFF_STATUS, 0);
    chk(r & 32'h70, 32'h10);
    apb(1, `BCT_OFF_ERRCNT, 0);
    apb(0, `BCT_OFF_ERRCNT, 0);
    chk(r, 0);
    ack_en <= 1'b1;
    // with the handler disabled a first fragment must be ignored
    apb(1, `BCT_OFF_CTRL, 32'h0000_0300);
    @(posedge mclk);
    send <= 1'b1;
    @(posedge mclk);
    send <= 1'b0;
    wait_out(p);
    chk(32'({rsp_valid, exec_start, busy}), 0);
    test_done();
  end
endmodule
